//--- verilog/ssq_pkg.sv
package ssq_pkg;
  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned US_CYC    = CLK_HZ / 1_000_000;
  localparam int unsigned INIT_US   = 200;
  localparam int unsigned INIT_CYC  = INIT_US * US_CYC;
  localparam int unsigned CHECK_CYC = 16;
  localparam int unsigned NSLOT     = 8;

  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_VOUT   = 3'h1;
  localparam logic [2:0] REG_UVLO   = 3'h2;
  localparam logic [2:0] REG_DELAY  = 3'h3;
  localparam logic [2:0] REG_RAMPUP = 3'h4;
  localparam logic [2:0] REG_RAMPDN = 3'h5;
  localparam logic [2:0] REG_TGT0   = 3'h6;
  localparam logic [2:0] REG_TGT1   = 3'h7;

  localparam int unsigned CTRL_SAVE_BIT = 8;
  localparam int unsigned ST_IDX_LSB    = 0;
  localparam int unsigned ST_CNT_LSB    = 3;
  localparam int unsigned ST_READY_BIT  = 7;
  localparam int unsigned ST_ON_LSB     = 8;
  localparam int unsigned ST_HIZ_LSB    = 10;

  localparam logic [15:0] VOUT_RST   = 16'h0200;
  localparam logic [15:0] UVLO_RST   = 16'h0100;
  localparam logic [15:0] DELAY_RST  = 16'h0000;
  localparam logic [15:0] RAMPUP_RST = 16'h03E8;
  localparam logic [15:0] RAMPDN_RST = 16'h03E8;

  localparam logic [15:0] STRAP_OHM [NSLOT] = '{16'h1A90, 16'h0708,
    16'h0898, 16'h0A8C, 16'h0CE4, 16'h0F3C, 16'h125C, 16'h15E0};

  typedef enum logic [4:0] {
    G_POR   = 5'h01,
    G_CHECK = 5'h02,
    G_LOAD  = 5'h04,
    G_UVLO  = 5'h08,
    G_READY = 5'h10
  } ssq_glob_t;

  typedef enum logic [4:0] {
    R_OFF   = 5'h01,
    R_DELAY = 5'h02,
    R_UP    = 5'h04,
    R_ON    = 5'h08,
    R_DOWN  = 5'h10
  } ssq_rail_t;

  function automatic logic [15:0] absdiff(input logic [15:0] a,
                                          input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic [2:0] strap_nearest(input logic [15:0] code);
    logic [15:0] best;
    best = absdiff(code, STRAP_OHM[0]);
    strap_nearest = 3'h0;
    for (int k = 1; k < NSLOT; k++) begin
      if (absdiff(code, STRAP_OHM[k]) < best) begin
        best = absdiff(code, STRAP_OHM[k]);
        strap_nearest = 3'(k);
      end
    end
  endfunction
endpackage

//--- verilog/ssq_sequencer.sv
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/100ps
module ssq_sequencer (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        por_ok,
  input  wire logic [15:0] vin_code,
  input  wire logic [15:0] strap_code,
  input  wire logic [1:0]  rail_enable_pair,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             core_reg_en,
  output logic             telemetry_en,
  output logic      [2:0]  profile_index,
  output logic      [1:0]  pwm_hiz,
  output logic      [1:0]  rail_active,
  output logic      [15:0] vtarget0,
  output logic      [15:0] vtarget1
);
  ssq_pkg::ssq_glob_t glob;
  ssq_pkg::ssq_rail_t rail_st [2];
  logic [4:0]  chk_cnt;
  logic [4:0]  div_cnt;
  logic        tick;
  logic [2:0]  strap_id;
  logic [3:0]  save_cnt;
  logic        nv_valid [ssq_pkg::NSLOT];
  logic [2:0]  nv_id    [ssq_pkg::NSLOT];
  logic [15:0] nv_prof  [ssq_pkg::NSLOT][5];
  logic [15:0] stage    [5];
  logic [15:0] act      [5];
  logic        hit;
  logic [2:0]  hit_slot;
  logic [15:0] us_cnt   [2];
  logic [11:0] cyc_cnt  [2];
  logic [15:0] vtgt     [2];
  logic [15:0] from_lvl [2];
  logic        save_req;

  // profile fields: 0 vout, 1 uvlo, 2 delay, 3 ramp up, 4 ramp down
  function automatic logic [15:0] ramp_level(input logic [15:0] lvl,
                                             input logic [15:0] el,
                                             input logic [15:0] tot);
    logic [31:0] prod;
    prod = 32'(lvl) * 32'(el);
    ramp_level = (el >= tot) ? lvl : 16'(prod / 32'(tot));
  endfunction

  assign strap_id = ssq_pkg::strap_nearest(strap_code);
  assign save_req = reg_wr && reg_addr == ssq_pkg::REG_CTRL
                    && reg_wdata[ssq_pkg::CTRL_SAVE_BIT];
  assign tick     = div_cnt == 5'(ssq_pkg::US_CYC - 1);
  assign vtarget0 = vtgt[0];
  assign vtarget1 = vtgt[1];

  // later slots are newer, so the last match is the newest save
  always_comb begin
    hit = 1'b0;
    hit_slot = 3'h0;
    for (int s = 0; s < ssq_pkg::NSLOT; s++) begin
      if (nv_valid[s] && nv_id[s] == strap_id) begin
        hit = 1'b1;
        hit_slot = 3'(s);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || tick) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      glob <= ssq_pkg::G_POR;
      chk_cnt <= 5'h00;
      core_reg_en <= 1'b0;
      telemetry_en <= 1'b0;
      profile_index <= 3'h0;
    end else if (!por_ok) begin
      glob <= ssq_pkg::G_POR;
      core_reg_en <= 1'b0;
      telemetry_en <= 1'b0;
    end else begin
      unique case (glob)
        ssq_pkg::G_POR: begin
          glob <= ssq_pkg::G_CHECK;
          chk_cnt <= 5'h00;
          core_reg_en <= 1'b1;
        end
        ssq_pkg::G_CHECK: begin
          chk_cnt <= chk_cnt + 5'h01;
          if (chk_cnt == 5'(ssq_pkg::CHECK_CYC - 1)) begin
            glob <= ssq_pkg::G_LOAD;
          end
        end
        ssq_pkg::G_LOAD: begin
          profile_index <= strap_id;
          telemetry_en <= 1'b1;
          glob <= ssq_pkg::G_UVLO;
        end
        ssq_pkg::G_UVLO: begin
          if (vin_code >= act[1]) begin
            glob <= ssq_pkg::G_READY;
          end
        end
        ssq_pkg::G_READY: begin
          glob <= ssq_pkg::G_READY;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int f = 0; f < 5; f++) begin
        act[f] <= 16'h0000;
      end
    end else if (glob == ssq_pkg::G_LOAD) begin
      for (int f = 0; f < 5; f++) begin
        act[f] <= hit ? nv_prof[hit_slot][f] : stage[f];
      end
    end
  end

  // save slots are not cleared by reset beyond the valid flags
  always_ff @(posedge clock) begin
    if (rst) begin
      save_cnt <= 4'h0;
      for (int s = 0; s < ssq_pkg::NSLOT; s++) begin
        nv_valid[s] <= 1'b0;
      end
    end else if (save_req && save_cnt < 4'(ssq_pkg::NSLOT)) begin
      save_cnt <= save_cnt + 4'h1;
      nv_valid[save_cnt[2:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (save_req && save_cnt < 4'(ssq_pkg::NSLOT)) begin
      nv_id[save_cnt[2:0]] <= reg_wdata[2:0];
      nv_prof[save_cnt[2:0]] <= stage;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stage[0] <= ssq_pkg::VOUT_RST;
      stage[1] <= ssq_pkg::UVLO_RST;
      stage[2] <= ssq_pkg::DELAY_RST;
      stage[3] <= ssq_pkg::RAMPUP_RST;
      stage[4] <= ssq_pkg::RAMPDN_RST;
    end else if (reg_wr && reg_addr >= ssq_pkg::REG_VOUT
                 && reg_addr <= ssq_pkg::REG_RAMPDN) begin
      stage[reg_addr - 3'h1] <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == ssq_pkg::REG_CTRL) begin
      reg_rdata <= '0;
      reg_rdata[ssq_pkg::ST_IDX_LSB +: 3] <= profile_index;
      reg_rdata[ssq_pkg::ST_CNT_LSB +: 4] <= save_cnt;
      reg_rdata[ssq_pkg::ST_READY_BIT] <= glob == ssq_pkg::G_READY;
      reg_rdata[ssq_pkg::ST_ON_LSB +: 2] <= rail_active;
      reg_rdata[ssq_pkg::ST_HIZ_LSB +: 2] <= pwm_hiz;
    end else if (reg_addr == ssq_pkg::REG_TGT0) begin
      reg_rdata <= vtgt[0];
    end else if (reg_addr == ssq_pkg::REG_TGT1) begin
      reg_rdata <= vtgt[1];
    end else begin
      reg_rdata <= stage[reg_addr - 3'h1];
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pwm_hiz[i] = rail_st[i] == ssq_pkg::R_OFF;
      rail_active[i] = rail_st[i] == ssq_pkg::R_ON;
    end
  end

  // an enable raised during ramp-down is ignored until the rail is off
  always_ff @(posedge clock) begin
    for (int i = 0; i < 2; i++) begin
      if (rst || glob != ssq_pkg::G_READY) begin
        rail_st[i] <= ssq_pkg::R_OFF;
        us_cnt[i] <= 16'h0000;
        cyc_cnt[i] <= 12'h000;
        vtgt[i] <= 16'h0000;
        from_lvl[i] <= 16'h0000;
      end else begin
        if (tick) begin
          us_cnt[i] <= us_cnt[i] + 16'h0001;
        end
        unique case (rail_st[i])
          ssq_pkg::R_OFF: begin
            vtgt[i] <= 16'h0000;
            if (rail_enable_pair[i]) begin
              rail_st[i] <= ssq_pkg::R_DELAY;
              us_cnt[i] <= 16'h0000;
              cyc_cnt[i] <= 12'h000;
            end
          end
          ssq_pkg::R_DELAY: begin
            if (cyc_cnt[i] < 12'(ssq_pkg::INIT_CYC)) begin
              cyc_cnt[i] <= cyc_cnt[i] + 12'h001;
            end
            if (!rail_enable_pair[i]) begin
              rail_st[i] <= ssq_pkg::R_OFF;
            end else if (us_cnt[i] >= act[2]
                && cyc_cnt[i] >= 12'(ssq_pkg::INIT_CYC)) begin
              us_cnt[i] <= 16'h0000;
              if (act[3] == 16'h0000) begin
                vtgt[i] <= act[0];
                rail_st[i] <= ssq_pkg::R_ON;
              end else begin
                rail_st[i] <= ssq_pkg::R_UP;
              end
            end
          end
          ssq_pkg::R_UP, ssq_pkg::R_ON: begin
            if (!rail_enable_pair[i]) begin
              from_lvl[i] <= vtgt[i];
              us_cnt[i] <= 16'h0000;
              rail_st[i] <= ssq_pkg::R_DOWN;
            end else if (rail_st[i] == ssq_pkg::R_UP) begin
              vtgt[i] <= ramp_level(act[0], us_cnt[i], act[3]);
              if (us_cnt[i] >= act[3]) begin
                rail_st[i] <= ssq_pkg::R_ON;
              end
            end
          end
          ssq_pkg::R_DOWN: begin
            vtgt[i] <= from_lvl[i]
                       - ramp_level(from_lvl[i], us_cnt[i], act[4]);
            if (us_cnt[i] >= act[4]) begin
              vtgt[i] <= 16'h0000;
              rail_st[i] <= ssq_pkg::R_OFF;
            end
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  AST_POR_CORE: assert property (
    glob == ssq_pkg::G_POR && por_ok |=> core_reg_en
      ##[16:16] glob == ssq_pkg::G_LOAD || !por_ok)
    else $error("core regulator or check timing wrong");

  AST_LOAD_TELEM: assert property (
    glob == ssq_pkg::G_LOAD && por_ok
      |=> telemetry_en && profile_index == $past(strap_id))
    else $error("profile not loaded or telemetry not started");

  AST_UVLO_HOLD: assert property (
    glob == ssq_pkg::G_UVLO && vin_code < act[1]
      |=> glob != ssq_pkg::G_READY)
    else $error("left undervoltage wait below threshold");

  AST_SHUT_START: assert property (
    glob == ssq_pkg::G_READY && por_ok && rail_st[0] == ssq_pkg::R_OFF
      && rail_enable_pair[0] |=> rail_st[0] == ssq_pkg::R_DELAY)
    else $error("rail did not leave shutdown on enable");

  AST_HIZ: assert property (
    glob != ssq_pkg::G_READY |=> pwm_hiz == 2'b11)
    else $error("pwm driven outside ready state");

  AST_DELAY_END: assert property (
    rail_st[0] == ssq_pkg::R_DELAY && rail_enable_pair[0]
      && us_cnt[0] < act[2] |=> rail_st[0] != ssq_pkg::R_UP)
    else $error("ramp started before delay elapsed");

  AST_INIT_WAIT: assert property (
    $past(rail_st[0]) == ssq_pkg::R_DELAY
      && rail_st[0] inside {ssq_pkg::R_UP, ssq_pkg::R_ON}
      |-> $past(cyc_cnt[0]) >= 12'(ssq_pkg::INIT_CYC))
    else $error("ramp began before initialisation time");

  AST_ZERO_RAMP: assert property (
    $past(rail_st[0]) == ssq_pkg::R_DELAY && rail_st[0] == ssq_pkg::R_ON
      |-> vtgt[0] == act[0] && act[3] == 16'h0000)
    else $error("zero ramp did not jump to target");

  AST_RAMP_BOUND: assert property (
    rail_st[0] == ssq_pkg::R_UP |=> vtgt[0] <= act[0]
      && vtgt[0] >= $past(vtgt[0]) || !rail_enable_pair[0])
    else $error("ramp target not monotonic or overshoots");

  AST_SAVE_LIMIT: assert property (
    save_req && save_cnt == 4'(ssq_pkg::NSLOT) |=> $stable(save_cnt))
    else $error("more than eight saves accepted");

  AST_STRAP_ZERO: assert property (
    strap_code == 16'h1A90 |-> strap_id == 3'h0)
    else $error("strap decode wrong for identifier zero");

  CVR_RAIL_ON: cover property (rail_st[0] == ssq_pkg::R_ON);
  CVR_RAIL_DOWN: cover property (
    rail_st[1] == ssq_pkg::R_DOWN ##1 rail_st[1] == ssq_pkg::R_OFF);
  CVR_SAVE_FULL: cover property (save_cnt == 4'(ssq_pkg::NSLOT));
  CVR_LOAD_HIT: cover property (glob == ssq_pkg::G_LOAD && hit);
endmodule

//--- testbench/ssq_far_side.sv
`timescale 1ns/100ps
module ssq_far_side (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [2:0]  strap_pick,
  input  wire logic [7:0]  strap_jit,
  input  wire logic [1:0]  en_req,
  output logic      [15:0] strap_code = 16'h1A90,
  output logic      [1:0]  rail_enable_pair = 2'h0
);
  int ohm [8] = '{6800, 1800, 2200, 2700, 3300, 3900, 4700, 5600};
  // signed jitter models tolerance; stays inside half the closest gap
  always @(posedge clock) begin
    strap_code <= 16'(ohm[strap_pick] + int'($signed(strap_jit)));
  end
  // system enable logic keeps both rails off through reset
  always @(posedge clock) begin
    rail_enable_pair <= rst ? 2'h0 : en_req;
  end
endmodule

//--- testbench/startup_profile_softstart_seq_tb.sv
`timescale 1ns/100ps
module startup_profile_softstart_seq_tb;
  typedef struct {int id; int vout; int up; int dly; int dn;} ssq_prof_t;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        por_ok = 1'b0;
  logic [15:0] vin_code = 16'h0000;
  logic [2:0]  strap_pick = 3'h0;
  logic [7:0]  strap_jit = 8'h00;
  logic [1:0]  en_req = 2'h0;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] strap_code, reg_rdata, vtarget0, vtarget1;
  logic [1:0]  rail_enable_pair, pwm_hiz, rail_active;
  logic        core_reg_en, telemetry_en;
  logic [2:0]  profile_index;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          seed = 32'h61AB13E0;
  ssq_prof_t   saved[$];
  ssq_prof_t   stg = '{0, 'h0200, 'h03E8, 0, 'h03E8};
  logic [15:0] rst_tab [6] = '{16'h0000, ssq_pkg::VOUT_RST, ssq_pkg::UVLO_RST,
    ssq_pkg::DELAY_RST, ssq_pkg::RAMPUP_RST, ssq_pkg::RAMPDN_RST};

  always #25 clock = ~clock;

  ssq_far_side far (.clock(clock), .rst(rst), .strap_pick(strap_pick),
    .strap_jit(strap_jit), .en_req(en_req), .strap_code(strap_code),
    .rail_enable_pair(rail_enable_pair));
  ssq_sequencer dut (.clock(clock), .rst(rst), .por_ok(por_ok),
    .vin_code(vin_code), .strap_code(strap_code),
    .rail_enable_pair(rail_enable_pair), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_reg_en(core_reg_en),
    .telemetry_en(telemetry_en), .profile_index(profile_index),
    .pwm_hiz(pwm_hiz), .rail_active(rail_active), .vtarget0(vtarget0),
    .vtarget1(vtarget1));

  task automatic give_verdict();
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic lim(input int n, input int max);
    if (n >= max) begin
      error_cnt++;
      $display("unexpected timeout: expected %0d, seen %0d", max, n);
      give_verdict();
    end
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic save(input int id, vout, up, dly, dn);
    logic [15:0] s;
    stg = '{id, vout, up, dly, dn};
    wr(3'h1, 16'(vout));
    wr(3'h3, 16'(dly));
    wr(3'h4, 16'(up));
    wr(3'h5, 16'(dn));
    wr(3'h0, 16'h0100 | 16'(id));
    if (saved.size() < 8) saved.push_back(stg);
    rd(3'h0, s);
    chk("save_count", 16'(saved.size()), {12'h000, s[6:3]});
  endtask
  // newest saved copy wins; staging applies when none carries the id
  function automatic ssq_prof_t pick(input int id);
    pick = stg;
    foreach (saved[i]) if (saved[i].id == id) pick = saved[i];
  endfunction
  task automatic power_up(input int id);
    int n;
    logic [15:0] s;
    por_ok <= 1'b0;
    vin_code <= 16'h00FF;
    strap_pick <= 3'(id);
    strap_jit <= 8'($random(seed));
    repeat (3) @(posedge clock);
    por_ok <= 1'b1;
    for (n = 0; n < 5 && core_reg_en !== 1'b1; n++) step();
    lim(n, 5);
    for (n = 0; n < 40 && telemetry_en !== 1'b1; n++) step();
    chk("init_cycles", 16'h0011, 16'(n));
    chk("profile_index", 16'(id), {13'h0, profile_index});
    @(posedge clock);
    en_req <= 2'h3;
    repeat (30) step();
    rd(3'h0, s);
    chk("not_ready", 16'h0C00, s & 16'h0C80);
    @(posedge clock);
    en_req <= 2'h0;
    vin_code <= 16'h0100;
    repeat (5) @(posedge clock);
    rd(3'h0, s);
    chk("ready", 16'h0C80, s & 16'h0C80);
  endtask
  task automatic rail_run(input int r, input ssq_prof_t p);
    int n, t0, mid, st, vt, prev, tol;
    st = (p.dly * 20 > 4000) ? p.dly * 20 : 4000;
    t0 = -1;
    prev = 0;
    mid = 0;
    chk("hiz_idle", 16'h0001, {15'h0, pwm_hiz[r]});
    @(posedge clock);
    en_req[r] <= 1'b1;
    for (n = 0; n < st + p.up * 20 + 50 && rail_active[r] !== 1'b1; n++) begin
      step();
      vt = r ? vtarget1 : vtarget0;
      if (n == 3) chk("hiz_run", 16'h0000, {15'h0, pwm_hiz[r]});
      if (vt != 0 && t0 < 0) t0 = n;
      if (vt < prev || vt > p.vout) chk("ramp_step", 16'(prev), 16'(vt));
      if (n == st + p.up * 10) mid = vt;
      prev = vt;
    end
    lim(n, st + p.up * 20 + 50);
    // enable crosses the far side one edge late; times count in whole
    // microsecond ticks of a free divider, so allow one tick of phase
    chk("ramp_start", 16'h0001, 16'(t0 >= st - 20 && t0 <= st + 25));
    chk("ramp_len", 16'h0001,
        16'(n - t0 + 21 >= p.up * 20 && n - t0 <= p.up * 20 + 3));
    chk("vtarget", 16'(p.vout), r ? vtarget1 : vtarget0);
    tol = (p.up > 0) ? 2 * p.vout / p.up + 2 : 0;
    if (p.up > 0) chk("ramp_mid", 16'h0001, 16'(mid >= p.vout / 2 - tol && mid <= p.vout / 2 + tol));
    @(posedge clock);
    en_req[r] <= 1'b0;
    for (n = 0; n < p.dn * 20 + 50 && pwm_hiz[r] !== 1'b1; n++) step();
    lim(n, p.dn * 20 + 50);
    chk("ramp_down", 16'h0001, 16'(n + 20 >= p.dn * 20));
    chk("vtarget_off", 16'h0000, r ? vtarget1 : vtarget0);
  endtask

  initial begin
    logic [15:0] s;
    repeat (10) @(posedge clock);
    #1 chk("hiz_reset", 16'h0003, {14'h0, pwm_hiz});
    @(posedge clock);
    rst <= 1'b0;
    for (int a = 1; a < 6; a++) begin
      rd(3'(a), s);
      chk("reset_value", rst_tab[a], s);
    end
    wr(3'h6, 16'hFFFF);
    rd(3'h6, s);
    chk("target_ro", 16'h0000, s);
    save(3, 'h0300, 0, 0, 2);
    save(0, 'h0400, 10, 300, 10);
    save(3, 'h0280, 0, 0, 2);
    for (int k = 0; k < 5; k++) save(5, 'h0100 + k, 4, 0, 4);
    save(0, 'h0123, 0, 0, 0);
    for (int k = 0; k < 8; k++) power_up(k);
    power_up(3);
    rail_run(0, pick(3));
    power_up(0);
    rail_run(1, pick(0));
    give_verdict();
  end
endmodule
